// ### hdl/sld_ctrl.sv
// Option decode and control signals of the synchronous line driver
//Contract
// - The three rate switches decode together to 1200, 2400, 4800, 7200, 9600, 14400 or 19200 bps.
// - Rate switches two and three both OFF give 19200 bps whatever switch one is.
// - Clock switch OFF makes and drives an internal transmit clock; ON times transmit data from the terminal's clock.
// - The recovered receive clock always goes to the terminal and never times transmission directly.
// - CTS follows a rise of RTS after zero, 8 ms or 53 ms as the two delay switches select.
// - Carrier switch OFF keeps carrier on; ON makes carrier follow RTS.
// - The reserved fourth switch has no effect on anything.
`timescale 1ns/1ps
`include "sld_map.svh"
module sld_ctrl
#(
	parameter int unsigned HALF_1200 = `SLD_HALF(`SLD_BPS_1200),
	parameter int unsigned HALF_2400 = `SLD_HALF(`SLD_BPS_2400),
	parameter int unsigned DLY_SHORT_CYC = `SLD_DLY_CYC(`SLD_DLY_SHORT_MS),
	parameter int unsigned DLY_LONG_CYC = `SLD_DLY_CYC(`SLD_DLY_LONG_MS)
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Terminal side
	input wire logic rts_i,
	input wire logic ext_clk_i,
	input wire logic txd_i,
	output logic cts_o,
	output logic tx_clk_o,
	output logic rx_clk_o,
	output logic rxd_o,
	// Line side
	input wire logic rec_clk_i,
	input wire logic line_rxd_i,
	output logic line_txd_o,
	output logic carrier_o
);

	localparam int NSYNC = 5;
	localparam int S_RTS = 0;
	localparam int S_EXT = 1;
	localparam int S_TXD = 2;
	localparam int S_REC = 3;
	localparam int S_RXD = 4;

	// Input synchronisers
	logic [NSYNC-1:0] pins;
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;

	assign pins = {line_rxd_i, rec_clk_i, txd_i, ext_clk_i, rts_i};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge clock_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi] <= pins[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	wire rts_s = sync_q[S_RTS];
	wire ext_s = sync_q[S_EXT];
	wire txd_s = sync_q[S_TXD];
	wire rec_s = sync_q[S_REC];
	wire rxd_s = sync_q[S_RXD];

	// Option switch bank register
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	wire acc_start = psel_i && penable_i && !pready_q;
	wire acc_done = psel_i && penable_i && pready_q;
	wire hit_cfg = (paddr_i == `SLD_OFF_CFG);
	wire hit_stat = (paddr_i == `SLD_OFF_STAT);
	wire hit_any = hit_cfg || hit_stat;
	wire cfg_we = acc_done && pwrite_i && hit_cfg;

	// Reserved position never stored
	assign cfg_d = pwdata_i[7:0] & `SLD_CFG_WMASK;

	wire [2:0] rate_sw = cfg_q[`SLD_SW_RATE_MSB:`SLD_SW_RATE_LSB];
	wire int_mode = !cfg_q[`SLD_SW_CLKSRC];
	wire dly_a_on = cfg_q[`SLD_SW_DLY_A];
	wire dly_b_on = cfg_q[`SLD_SW_DLY_B];
	wire carr_rts = cfg_q[`SLD_SW_CARR];

	// Rate decode, ON reads as one
	sld_pkg::sld_half_cnt_t half_cnt;
	assign half_cnt =
		(rate_sw == 3'h7) ? 14'(HALF_1200) :
		(rate_sw == 3'h6) ? 14'(HALF_2400) :
		(rate_sw == 3'h5) ? 14'(`SLD_HALF(`SLD_BPS_4800)) :
		(rate_sw == 3'h3) ? 14'(`SLD_HALF(`SLD_BPS_7200)) :
		(rate_sw == 3'h4) ? 14'(`SLD_HALF(`SLD_BPS_9600)) :
		(rate_sw == 3'h2) ? 14'(`SLD_HALF(`SLD_BPS_14400)) :
		14'(`SLD_HALF(`SLD_BPS_19200));

	// Delay decode, the unlisted code takes the long delay
	wire dly_zero = dly_a_on && dly_b_on;
	wire dly_short = dly_a_on && !dly_b_on;
	sld_pkg::sld_dly_cnt_t dly_cnt;
	assign dly_cnt = dly_short ? 21'(DLY_SHORT_CYC) : 21'(DLY_LONG_CYC);

	// Internal transmit clock divider
	sld_pkg::sld_half_cnt_t div_q;
	logic int_clk_q;
	wire div_wrap = (div_q == 14'h0000);

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div_q <= 14'h0000;
			int_clk_q <= 1'b0;
		end
		else if (div_wrap)
		begin
			div_q <= half_cnt - 14'h0001;
			int_clk_q <= !int_clk_q;
		end
		else
		begin
			div_q <= div_q - 14'h0001;
		end
	end

	// Transmit timing edge from the selected source
	logic ext_d_q;
	wire int_rise = div_wrap && !int_clk_q;
	wire ext_rise = ext_s && !ext_d_q;
	wire tx_edge = int_mode ? int_rise : ext_rise;

	// CTS delay timer
	logic cts_w;

	sld_cts_delay u_cts
	(
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.rts_i(rts_s),
		.zero_i(dly_zero),
		.dly_i(dly_cnt),
		.cts_o(cts_w)
	);

	// Carrier follows RTS or stays on
	wire carr_d = carr_rts ? rts_s : 1'b1;

	// Output and pin registers
	logic cts_q;
	logic carr_q;
	logic tx_clk_q;
	logic rx_clk_q;
	logic rxd_q;
	logic line_txd_q;

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ext_d_q <= 1'b0;
			cts_q <= 1'b0;
			carr_q <= 1'b0;
			tx_clk_q <= 1'b0;
			rx_clk_q <= 1'b0;
			rxd_q <= 1'b1;
			line_txd_q <= 1'b1;
		end
		else
		begin
			ext_d_q <= ext_s;
			cts_q <= cts_w && rts_s;
			carr_q <= carr_d;
			tx_clk_q <= int_mode && int_clk_q;
			rx_clk_q <= rec_s;
			rxd_q <= rxd_s;
			if (tx_edge)
				line_txd_q <= txd_s;
		end
	end

	// Status word
	logic [31:0] stat_w;
	assign stat_w = {21'h000000, rate_sw, 4'h0, int_mode, carr_q, cts_q, rts_s};

	wire [31:0] rd_w = hit_cfg ? {24'h000000, cfg_q} :
		hit_stat ? stat_w : 32'h00000000;

	// APB slave, answers in the second access cycle
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cfg_q <= `SLD_CFG_RESET;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= acc_start;
			pslverr_q <= acc_start && !hit_any;
			if (acc_start && !pwrite_i)
				prdata_q <= rd_w;
			if (cfg_we)
				cfg_q <= cfg_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign cts_o = cts_q;
	assign carrier_o = carr_q;
	assign tx_clk_o = tx_clk_q;
	assign rx_clk_o = rx_clk_q;
	assign rxd_o = rxd_q;
	assign line_txd_o = line_txd_q;

	// Checks
	rate_decode_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rate_sw == 3'h4) |-> (half_cnt == 14'd1302))
		else $error("9600 rate decoded wrongly");

	rate_alias_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rate_sw[2:1] == 2'b00) |-> (half_cnt == 14'd651))
		else $error("19200 codes differ");

	int_clk_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		int_mode && $past(int_mode) && !$past(div_wrap)
		|=> $stable(tx_clk_o))
		else $error("internal clock moved off divider wrap");

	sequence ext_edge_s;
		!int_mode && ext_rise;
	endsequence

	ext_clk_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		ext_edge_s |=> (line_txd_o == $past(txd_s)) && !tx_clk_o)
		else $error("external clock not timing transmit");

	rx_clk_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		##1 (rx_clk_o == $past(rec_s)))
		else $error("recovered clock not passed");

	carr_const_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!carr_rts |=> carrier_o)
		else $error("carrier dropped in constant mode");

	carr_rts_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		carr_rts && $fell(rts_s) |=> !carrier_o && !cts_o)
		else $error("carrier or cts late to drop");

	rsvd_bit_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		cfg_we |=> (cfg_q[`SLD_SW_RSVD] == 1'b0))
		else $error("reserved switch stored");

	long_dly_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!dly_a_on |-> (dly_cnt == 21'(DLY_LONG_CYC)))
		else $error("unlisted delay code not long");

	ext_tx_low_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!int_mode |=> !tx_clk_o)
		else $error("transmit clock driven in external mode");

	carr_follow_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		carr_rts |=> (carrier_o == $past(rts_s)))
		else $error("carrier not following rts");

	cts_gated_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		cts_o |-> $past(rts_s))
		else $error("cts high without rts");

	rate_fast_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rate_sw == 3'h2) |-> (half_cnt == 14'd868))
		else $error("14400 rate decoded wrongly");

	rsvd_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!cfg_q[`SLD_SW_RSVD])
		else $error("reserved switch reads set");

endmodule

// ### hdl/sld_cts_delay.sv
// Clear-to-send delay timer
`timescale 1ns/1ps
module sld_cts_delay
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Control
	input wire logic rts_i,
	input wire logic zero_i,
	input wire sld_pkg::sld_dly_cnt_t dly_i,
	// Result
	output logic cts_o
);

	sld_pkg::sld_cts_state_t state_q;
	sld_pkg::sld_cts_state_t state_d;
	sld_pkg::sld_dly_cnt_t cnt_q;
	sld_pkg::sld_dly_cnt_t cnt_d;
	logic cnt_last;

	assign cnt_last = (cnt_q <= 21'h000001);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			sld_pkg::SLD_CTS_IDLE:
			begin
				if (rts_i && zero_i)
					state_d = sld_pkg::SLD_CTS_ON;
				else if (rts_i)
				begin
					state_d = sld_pkg::SLD_CTS_WAIT;
					cnt_d = dly_i;
				end
			end
			sld_pkg::SLD_CTS_WAIT:
			begin
				if (!rts_i)
					state_d = sld_pkg::SLD_CTS_IDLE;
				else if (cnt_last)
					state_d = sld_pkg::SLD_CTS_ON;
				else
					cnt_d = cnt_q - 21'h000001;
			end
			sld_pkg::SLD_CTS_ON:
			begin
				if (!rts_i)
					state_d = sld_pkg::SLD_CTS_IDLE;
			end
			default:
				state_d = sld_pkg::SLD_CTS_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q <= sld_pkg::SLD_CTS_IDLE;
			cnt_q <= 21'h000000;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign cts_o = state_q[2];

	// Checks
	sequence rts_rise_s;
		$rose(rts_i) && zero_i;
	endsequence

	cts_zero_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		rts_rise_s |=> cts_o)
		else $error("cts late with zero delay");

	cts_early_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(state_q == sld_pkg::SLD_CTS_WAIT) && !cnt_last |=> !cts_o)
		else $error("cts raised before delay ended");

	cts_drop_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!rts_i |=> !cts_o)
		else $error("cts held after rts fell");

endmodule

// ### hdl/sld_map.svh
// Offsets, switch fields, reset values and timing counts of the line driver
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// Core clock
`define SLD_CLK_HZ 25000000

// Register byte offsets
`define SLD_OFF_CFG 8'h00
`define SLD_OFF_STAT 8'h04

// Option switch bank fields, bit set means switch ON
`define SLD_SW_RATE_LSB 0
`define SLD_SW_RATE_MSB 2
`define SLD_SW_RSVD 3
`define SLD_SW_CLKSRC 4
`define SLD_SW_DLY_A 5
`define SLD_SW_DLY_B 6
`define SLD_SW_CARR 7
`define SLD_CFG_RESET 8'h24
`define SLD_CFG_WMASK 8'hf7

// Status fields
`define SLD_ST_RTS 0
`define SLD_ST_CTS 1
`define SLD_ST_CARR 2
`define SLD_ST_INT 3
`define SLD_ST_RATE_LSB 8

// Data rates in bps
`define SLD_BPS_1200 1200
`define SLD_BPS_2400 2400
`define SLD_BPS_4800 4800
`define SLD_BPS_7200 7200
`define SLD_BPS_9600 9600
`define SLD_BPS_14400 14400
`define SLD_BPS_19200 19200

// Half periods of the internal transmit clock in core cycles
`define SLD_HALF(bps) (`SLD_CLK_HZ / (2 * (bps)))

// RTS to CTS delays in ms and core cycles
`define SLD_DLY_SHORT_MS 8
`define SLD_DLY_LONG_MS 53
`define SLD_DLY_CYC(ms) (((ms) * `SLD_CLK_HZ) / 1000)

`endif

// ### hdl/sld_pkg.sv
// Types shared by the line driver control logic
package sld_pkg;

	typedef enum logic [2:0]
	{
		SLD_CTS_IDLE = 3'b001,
		SLD_CTS_WAIT = 3'b010,
		SLD_CTS_ON = 3'b100
	} sld_cts_state_t;

	typedef logic [20:0] sld_dly_cnt_t;
	typedef logic [13:0] sld_half_cnt_t;

endpackage

// ### testbench/sld_ctrl_tb_top.sv
// Testbench of the line driver control logic
`timescale 1ns/1ps
`include "sld_map.svh"
module sld_ctrl_tb_top;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic rts = 1'b0, rec_clk = 1'b0, line_rxd = 1'b0, ext_en = 1'b0;
	logic pready, pslverr, cts, tx_clk, rx_clk, rxd, line_txd, carrier;
	logic ext_clk, txd;
	int errors = 0;
	int checked = 0;
	always #20 clock_i = ~clock_i;
	sld_ctrl #(.HALF_1200(20), .HALF_2400(10), .DLY_SHORT_CYC(40),
		.DLY_LONG_CYC(100)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .rts_i(rts),
		.ext_clk_i(ext_clk), .txd_i(txd), .cts_o(cts), .tx_clk_o(tx_clk),
		.rx_clk_o(rx_clk), .rxd_o(rxd), .rec_clk_i(rec_clk),
		.line_rxd_i(line_rxd), .line_txd_o(line_txd), .carrier_o(carrier));
	sld_dte_model u_dte (.ext_en_i(ext_en), .tx_clk_i(tx_clk),
		.ext_clk_o(ext_clk), .txd_o(txd));
	task results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_rng(input int n, input int lo, input int hi);
		checked++;
		if (n < lo || n > hi)
		begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, n, lo);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		chk(pready, 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task till(input logic v, inout int n);
		while (tx_clk !== v && n < 20000)
		begin
			@(posedge clock_i);
			n++;
		end
	endtask
	task period(input logic [31:0] c, output int p);
		int n;
		n = 0;
		apb(1'b1, 8'h00, c);
		till(1'b0, n);
		till(1'b1, n);
		till(1'b0, n);
		p = 0;
		till(1'b1, p);
		chk(line_txd, txd);
	endtask
	task rxpass;
		repeat (4)
		begin
			rec_clk <= ~rec_clk;
			line_rxd <= ~line_rxd;
			cyc(5);
			chk({rx_clk, rxd}, {rec_clk, line_rxd});
		end
	endtask
	task t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h24);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd[3], 1'b1);
		apb(1'b1, 8'h08, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, 8'h08, 32'h0);
		chk({err, rd[7:0]}, 9'h100);
		$display("regs done");
	endtask
	task t_rate;
		int p, q, i;
		logic [2:0] code [5] = '{3'h5, 3'h3, 3'h4, 3'h2, 3'h1};
		int half [5] = '{`SLD_HALF(`SLD_BPS_4800),
			`SLD_HALF(`SLD_BPS_7200), `SLD_HALF(`SLD_BPS_9600),
			`SLD_HALF(`SLD_BPS_14400), `SLD_HALF(`SLD_BPS_19200)};
		period(32'h67, p);
		chk(p, 20);
		period(32'h66, p);
		chk(p, 10);
		period(32'h6e, p);
		chk(p, 10);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h66);
		for (i = 0; i < 5; i++)
		begin
			period({29'h0c, code[i]}, p);
			chk(p, half[i]);
		end
		period(32'h60, q);
		chk(q, p);
		rxpass();
		$display("rate done");
	endtask
	task t_dly;
		int n, i;
		logic [31:0] c [4] = '{32'he4, 32'ha4, 32'h84, 32'hc4};
		int lo [4] = '{2, 40, 100, 100};
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, 8'h00, c[i]);
			cyc(2);
			chk(carrier, 1'b0);
			rts <= 1'b1;
			n = 0;
			while (cts !== 1'b1 && n < 300)
			begin
				@(posedge clock_i);
				n++;
			end
			chk_rng(n, lo[i], lo[i] + 8);
			chk(carrier, 1'b1);
			rts <= 1'b0;
			cyc(5);
			chk({cts, carrier}, 2'b00);
		end
		rts <= 1'b1;
		cyc(60);
		rts <= 1'b0;
		cyc(4);
		rts <= 1'b1;
		cyc(90);
		chk(cts, 1'b0);
		rts <= 1'b0;
		apb(1'b1, 8'h00, 32'h24);
		cyc(3);
		chk(carrier, 1'b1);
		$display("delay done");
	endtask
	task t_ext;
		logic prev;
		apb(1'b1, 8'h00, 32'h34);
		ext_en <= 1'b1;
		@(posedge ext_clk);
		prev = txd;
		repeat (8)
		begin
			@(posedge ext_clk);
			chk({line_txd, tx_clk}, {prev, 1'b0});
			prev = txd;
		end
		@(posedge clock_i);
		rxpass();
		ext_en <= 1'b0;
		$display("ext done");
	endtask
	initial
	begin
		cyc(4);
		chk({rxd, line_txd, carrier, cts}, 4'b1100);
		@(posedge clock_i);
		nrst_i <= 1'b1;
		cyc(2);
		chk(carrier, 1'b1);
		t_regs();
		t_rate();
		t_dly();
		t_ext();
		results();
	end
	initial
	begin
		#3000000;
		errors++;
		results();
	end
endmodule

// ### testbench/sld_dte_model.sv
// Terminal model: external clock and transmit data
`timescale 1ns/1ps
module sld_dte_model
(
	// Control
	input wire logic ext_en_i,
	input wire logic tx_clk_i,
	// Terminal pins
	output logic ext_clk_o,
	output logic txd_o
);
	logic [7:0] pat_q = 8'h4b;
	logic clk_q = 1'b0;
	// Clock runs only while enabled
	always #160 clk_q = ext_en_i ? ~clk_q : 1'b0;
	assign ext_clk_o = clk_q;
	// New bit on the falling edge of the active clock
	always @(negedge clk_q or negedge tx_clk_i)
	begin
		pat_q <= {pat_q[6:0], pat_q[7]};
	end
	assign txd_o = pat_q[7];
endmodule
